// [hw/qrst_cfg.svh]
// timing and width constants of the quasi-resonant switch timing core
`ifndef QRST_CFG_SVH
`define QRST_CFG_SVH
`define QRST_CLK_NS 50
`define QRST_VALLEY_MAX 3'h7
`define QRST_VALLEY_ZERO 3'h0
`define QRST_TARGET_MIN 3'h1
`define QRST_TARGET_MAX 3'h7
`define QRST_BURST_TARGET 3'h7
// times in ns
`define QRST_RING_SHORT_NS 2500
`define QRST_RING_LONG_NS 25000
`define QRST_MAX_OFF_NS 50000
`define QRST_MAX_ON_NS 25000
`define QRST_LEB_NS 250
`define QRST_SW_BLANK_NS 190
`define QRST_OVP_BLANK_NS 100000
`define QRST_BURST_BLANK_NS 24000000
// least times round up, longest round down
`define QRST_CYC_UP(t) (((t) + `QRST_CLK_NS - 1) / `QRST_CLK_NS)
`define QRST_CYC_DN(t) ((t) / `QRST_CLK_NS)
`define QRST_RING_SHORT_CYC `QRST_CYC_UP(`QRST_RING_SHORT_NS)
`define QRST_RING_LONG_CYC `QRST_CYC_UP(`QRST_RING_LONG_NS)
`define QRST_MAX_OFF_CYC `QRST_CYC_DN(`QRST_MAX_OFF_NS)
`define QRST_MAX_ON_CYC `QRST_CYC_DN(`QRST_MAX_ON_NS)
`define QRST_LEB_CYC `QRST_CYC_UP(`QRST_LEB_NS)
`define QRST_SW_BLANK_CYC `QRST_CYC_UP(`QRST_SW_BLANK_NS)
`define QRST_OVP_BLANK_CYC `QRST_CYC_UP(`QRST_OVP_BLANK_NS)
`define QRST_BURST_BLANK_CYC `QRST_CYC_UP(`QRST_BURST_BLANK_NS)
`define QRST_OFFSET_W 4
`endif

// [hw/qrst_pkg.sv]
// types of the quasi-resonant switch timing core
package qrst_pkg;
  typedef enum logic [1:0] {QRST_OFF, QRST_ON, QRST_LATCHED} qrst_phase_t;
endpackage : qrst_pkg

// [hw/qrst_persist.sv]
// persistence filter: output rises once input has held for blank cycles
`timescale 1ns/100ps
`include "qrst_cfg.svh"
module qrst_persist #(
  parameter int unsigned CW = 8
) (
  input wire logic mclk, // system clock
  input wire logic reset, // synchronous reset, active high
  input wire logic enable, // qualify window
  input wire logic level, // raw comparator level
  input wire logic [CW-1:0] blank, // cycles the level must persist
  output logic held // level persisted long enough
);
  typedef struct packed {
    logic [CW-1:0] count;
    logic held;
  } qrst_pst_t;
  qrst_pst_t st;
  qrst_pst_t next_st;

  // count while qualified, restart from zero on any break
  always_comb
  begin
    next_st = st;
    if (!(enable && level))
    begin
      next_st.count = '0;
      next_st.held = 1'b0;
    end
    else if (st.count >= blank - CW'(1))
      next_st.held = 1'b1;
    else
      next_st.count = st.count + CW'(1);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  assign held = st.held;
endmodule : qrst_persist

// [hw/qrst_core.sv]
// switching-timing core of the quasi-resonant flyback controller
//
// Contract
// - valley counter ranges 0..7 and saturates at 7
// - after turn-off each falling valley crossing adds one
// - valley counter cleared whenever the gate goes high
// - overvoltage held through blanking while off latches gate low
// - ringing mask long when sense low at turn-off, otherwise short
// - gate stays low during the whole ringing mask
// - after mask, turn on when valley count reaches target
// - after max off-time turn on regardless of counts
// - turn off when scaled current exceeds feedback voltage
// - pwm and current-limit comparators ignored during leading-edge blanking
// - gate forced off after maximum on-time
// - current-limit trip turns gate off in the same cycle
// - short-winding comparator acts only after spike blanking
// - foldback current excess sets the current limit offset
// - burst set when feedback low and target 7 for 24 ms
// - target count used is clamped to 1..7
// - overvoltage latch cleared only by power-down reset
// - short-winding latch disabled in burst mode
`timescale 1ns/100ps
`include "qrst_cfg.svh"
module qrst_core
  import qrst_pkg::*;
#(
  parameter int unsigned OVP_BLANK = `QRST_OVP_BLANK_CYC,
  parameter int unsigned BURST_BLANK = `QRST_BURST_BLANK_CYC
) (
  input wire logic mclk, // 20 MHz clock
  input wire logic reset, // power-down reset, sync, active high
  input wire logic valley_below, // sense below valley_detect_threshold
  input wire logic ring_mask_select_low, // sense below ring_mask_select_threshold
  input wire logic output_overvoltage, // sense above output_overvoltage_threshold
  input wire logic pwm_trip, // scaled current above feedback_voltage
  input wire logic current_limit_trip, // current above adjusted limit
  input wire logic short_winding, // current above short_winding_threshold
  input wire logic feedback_below_burst, // feedback below burst_entry_feedback_threshold
  input wire logic foldback_over, // sense current above foldback_current_threshold
  input wire logic [`QRST_OFFSET_W-1:0] foldback_excess, // quantised excess current
  input wire logic [2:0] target_count, // load-set target from up/down counter
  output logic gate_output, // gate drive, high = switch on
  output logic latched_off, // latched protection state
  output logic burst_mode, // burst-mode flip-flop
  output logic [`QRST_OFFSET_W-1:0] limit_offset, // current-limit reduction
  output logic [2:0] valley_count // present valley count
);
  localparam int unsigned TW = 20;
  localparam int unsigned BW = 24;
  localparam logic [TW-1:0] RING_SHORT = TW'(`QRST_RING_SHORT_CYC);
  localparam logic [TW-1:0] RING_LONG = TW'(`QRST_RING_LONG_CYC);
  localparam logic [TW-1:0] MAX_OFF = TW'(`QRST_MAX_OFF_CYC);
  localparam logic [TW-1:0] MAX_ON = TW'(`QRST_MAX_ON_CYC);
  localparam logic [TW-1:0] LEB = TW'(`QRST_LEB_CYC);
  localparam logic [TW-1:0] SW_BLANK = TW'(`QRST_SW_BLANK_CYC);

  typedef struct packed {
    qrst_phase_t phase;
    logic [TW-1:0] timer;
    logic [TW-1:0] ring_len;
    logic [2:0] valleys;
    logic valley_prev;
    logic burst;
    logic [`QRST_OFFSET_W-1:0] offset;
  } qrst_state_t;
  qrst_state_t st;
  qrst_state_t next_st;

  logic ovp_held;
  logic sw_held;
  logic burst_held;
  logic [2:0] target_eff;
  logic leb_over;
  logic cut_now;

  assign target_eff = (target_count < `QRST_TARGET_MIN) ? `QRST_TARGET_MIN : target_count;

  qrst_persist #(.CW(TW)) u_ovp (
    .mclk(mclk),
    .reset(reset),
    .enable(st.phase == QRST_OFF),
    .level(output_overvoltage),
    .blank(TW'(OVP_BLANK)),
    .held(ovp_held)
  );

  // short-winding spike blanking, off in burst
  qrst_persist #(.CW(TW)) u_sw (
    .mclk(mclk),
    .reset(reset),
    .enable(st.phase == QRST_ON && !st.burst),
    .level(short_winding),
    .blank(SW_BLANK),
    .held(sw_held)
  );

  // burst entry qualification, restarts on any break
  qrst_persist #(.CW(BW)) u_burst (
    .mclk(mclk),
    .reset(reset),
    .enable(target_count == `QRST_BURST_TARGET),
    .level(feedback_below_burst),
    .blank(BW'(BURST_BLANK)),
    .held(burst_held)
  );

  // blanking over once timer passed leading edge
  assign leb_over = st.timer >= LEB;
  // combinational cut so the limit acts within the trip cycle
  assign cut_now = st.phase == QRST_ON && leb_over && current_limit_trip;

  // next-state logic of the gate sequencer
  always_comb
  begin
    next_st = st;
    next_st.valley_prev = valley_below;
    // offset tracks foldback excess, zero below threshold
    next_st.offset = foldback_over ? foldback_excess : '0;
    if (burst_held)
      next_st.burst = 1'b1;
    case (st.phase)
      QRST_ON:
      begin
        next_st.timer = st.timer + TW'(1);
        if ((leb_over && (pwm_trip || current_limit_trip)) || st.timer >= MAX_ON)
        begin
          next_st.phase = QRST_OFF;
          next_st.timer = '0;
          next_st.ring_len = ring_mask_select_low ? RING_LONG : RING_SHORT;
        end
      end
      QRST_OFF:
      begin
        next_st.timer = (st.timer == '1) ? st.timer : st.timer + TW'(1);
        if (valley_below && !st.valley_prev && st.valleys != `QRST_VALLEY_MAX)
          next_st.valleys = st.valleys + 3'h1;
        // max off-time wins; else valley vs target after mask
        if (st.timer >= MAX_OFF - TW'(1) ||
            (st.timer >= st.ring_len && st.valleys >= target_eff))
        begin
          next_st.phase = QRST_ON;
          next_st.timer = '0;
          next_st.valleys = `QRST_VALLEY_ZERO;
        end
      end
      QRST_LATCHED:
        next_st.timer = '0;
      default:
        next_st.phase = QRST_LATCHED;
    endcase
    // latch off; only reset leaves it
    if (ovp_held || sw_held)
      next_st.phase = QRST_LATCHED;
  end

  // state register; reset is the power-down reset
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st <= '0;
      st.phase <= QRST_OFF;
      st.ring_len <= RING_LONG;
      // a quiet sense pin sits below the valley threshold; a low reset value
      // would count a false valley on the first edge after reset
      st.valley_prev <= 1'h1;
    end
    else
      st <= next_st;
  end

  // gate is registered but cut immediately by the limit comparator
  assign gate_output = st.phase == QRST_ON && !cut_now;
  assign latched_off = st.phase == QRST_LATCHED;
  assign burst_mode = st.burst;
  assign limit_offset = st.offset;
  assign valley_count = st.valleys;

  valley_sat_a: assert property (@(posedge mclk) disable iff (reset)
    ($past(st.valleys) == 3'h7 && st.phase == QRST_OFF) |-> st.valleys == 3'h7)
    else $error("valley counter wrapped");
  valley_clear_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(st.phase == QRST_ON) |-> st.valleys == 3'h0)
    else $error("valley counter not cleared at turn-on");
  ring_mask_a: assert property (@(posedge mclk) disable iff (reset)
    (st.phase == QRST_OFF && st.timer < st.ring_len && st.timer < MAX_OFF - TW'(1))
      |=> st.phase != QRST_ON)
    else $error("gate rose inside ringing mask");
  max_off_a: assert property (@(posedge mclk) disable iff (reset)
    (st.phase == QRST_OFF && st.timer == MAX_OFF - TW'(1) && !ovp_held) |=> st.phase == QRST_ON)
    else $error("max off-time missed");
  max_on_a: assert property (@(posedge mclk) disable iff (reset)
    st.phase == QRST_ON |-> st.timer <= MAX_ON)
    else $error("on-time exceeded");
  leb_hold_a: assert property (@(posedge mclk) disable iff (reset)
    (st.phase == QRST_ON && st.timer < LEB) |-> gate_output)
    else $error("gate cut inside blanking");
  limit_cut_a: assert property (@(posedge mclk) disable iff (reset)
    (st.phase == QRST_ON && leb_over && current_limit_trip) |-> !gate_output)
    else $error("current limit did not cut gate");
  latch_keep_a: assert property (@(posedge mclk) disable iff (reset)
    latched_off |=> latched_off)
    else $error("latched state released");
  burst_set_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(st.burst) |-> $past(target_count) == 3'h7 && $past(feedback_below_burst, 2))
    else $error("burst set without conditions");
endmodule : qrst_core

// [bench/qrst_plant.sv]
// partner model: power switch, ringing auxiliary winding and feedback trip
`timescale 1ns/100ps
module qrst_plant (
  input wire logic mclk, // system clock
  input wire logic gate_output, // gate drive from the core
  input wire logic ring_en, // winding rings after turn-off
  input wire logic trip_en, // feedback trips while the switch conducts
  output logic valley_below, // sense below valley threshold
  output logic pwm_trip // scaled current above feedback
);
  // ringing phase starts at zero so the valleys fall at known cycles
  logic [4:0] ph = 5'h00;
  // ringing of 32 cycles restarts at each turn-off; no ringing while on
  always @(negedge mclk)
  begin
    // an unknown gate before the first reset edge counts as on
    ph <= (gate_output === 1'h0) ? ph + 5'h01 : 5'h00;
    valley_below <= ring_en & ~gate_output & ph[4];
    pwm_trip <= trip_en & gate_output;
  end
endmodule : qrst_plant

// [bench/qrst_core_tb.sv]
// self-checking bench of the switch timing core
`timescale 1ns/100ps
module qrst_core_tb;
  logic mclk, reset, ring_en, trip_en, valley_below, pwm_trip, rms, ovp, clt, sw, fbl, fo;
  logic gate_output, latched_off, burst_mode;
  logic [3:0] fx, limit_offset;
  logic [2:0] tgt, valley_count;
  int n_fail, check_count, n;
  typedef struct {logic o; logic [3:0] x; logic [3:0] e;} qrst_row_t;
  // foldback rows: over flag, excess, expected offset
  qrst_row_t rows [4] = '{'{1'h1, 4'h3, 4'h3}, '{1'h0, 4'h9, 4'h0},
    '{1'h1, 4'hf, 4'hf}, '{1'h1, 4'h0, 4'h0}};
  // small blanking counts keep the run short
  qrst_core #(.OVP_BLANK(20), .BURST_BLANK(50)) qrst_core_i (.mclk(mclk), .reset(reset),
    .valley_below(valley_below), .ring_mask_select_low(rms), .output_overvoltage(ovp),
    .pwm_trip(pwm_trip), .current_limit_trip(clt), .short_winding(sw),
    .feedback_below_burst(fbl), .foldback_over(fo), .foldback_excess(fx),
    .target_count(tgt), .gate_output(gate_output), .latched_off(latched_off),
    .burst_mode(burst_mode), .limit_offset(limit_offset), .valley_count(valley_count));
  qrst_plant qrst_plant_i (.mclk(mclk), .gate_output(gate_output), .ring_en(ring_en),
    .trip_en(trip_en), .valley_below(valley_below), .pwm_trip(pwm_trip));
  initial
  begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask : cyc
  task automatic chk(input logic [3:0] g, input logic [3:0] e);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_in(input int v, input int lo, input int hi);
    check_count++;
    if (v < lo || v > hi)
    begin
      n_fail++;
      $display("BAD %0t cycles %0d", $time, v);
    end
  endtask : chk_in
  // bounded wait for a gate level, cycles waited in n
  task automatic wait_gate(input logic lv, input int lim);
    n = 0;
    while (gate_output !== lv && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask : wait_gate
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // watchdog well beyond the 5300 cycles the tests take
  initial
  begin
    #400000;
    n_fail++;
    end_of_test();
  end
  initial
  begin
    reset = 1'h1;
    ring_en = 1'h1;
    trip_en = 1'h0;
    rms = 1'h1;
    {ovp, clt, sw, fbl, fo} = 5'h00;
    fx = 4'h0;
    tgt = 3'h7;
    // step off time zero so the clock's first fall is not counted as a cycle
    #1;
    cyc(20);
    chk({gate_output, latched_off, burst_mode, valley_count == 3'h0}, 4'h1);
    reset = 1'h0;
    foreach (rows[i])
    begin
      fo = rows[i].o;
      fx = rows[i].x;
      cyc(2);
      chk(limit_offset, rows[i].e);
    end
    fo = 1'h0;
    $display("foldback test done");
    cyc(392);
    chk({1'h0, valley_count}, 4'h7);
    chk({3'h0, gate_output}, 4'h0);
    wait_gate(1'h1, 200);
    chk_in(n, 95, 105);
    cyc(1);
    chk({1'h0, valley_count}, 4'h0);
    $display("valley test done");
    rms = 1'h0;
    tgt = 3'h3;
    wait_gate(1'h0, 600);
    chk_in(n, 495, 505);
    // short mask is over before the third valley, which then turns the gate on
    wait_gate(1'h1, 200);
    chk_in(n, 80, 84);
    trip_en = 1'h1;
    wait_gate(1'h0, 20);
    chk_in(n, 4, 7);
    $display("on-time test done");
    trip_en = 1'h0;
    ring_en = 1'h0;
    rms = 1'h1;
    tgt = 3'h0;
    // no valleys: a zero target taken as one must wait for the max off-time
    wait_gate(1'h1, 1100);
    chk_in(n, 990, 1005);
    cyc(6);
    sw = 1'h1;
    cyc(3);
    sw = 1'h0;
    cyc(2);
    chk({3'h0, latched_off}, 4'h0);
    clt = 1'h1;
    #1;
    chk({3'h0, gate_output}, 4'h0);
    cyc(1);
    clt = 1'h0;
    $display("off-time test done");
    ovp = 1'h1;
    cyc(19);
    chk({3'h0, latched_off}, 4'h0);
    cyc(6);
    ovp = 1'h0;
    cyc(1);
    chk({3'h0, latched_off}, 4'h1);
    wait_gate(1'h1, 1100);
    chk({2'h0, gate_output, latched_off}, 4'h1);
    reset = 1'h1;
    cyc(2);
    reset = 1'h0;
    cyc(1);
    chk({3'h0, latched_off}, 4'h0);
    $display("latch test done");
    // low feedback alone must not enter burst while the target is below seven
    tgt = 3'h6;
    fbl = 1'h1;
    cyc(60);
    chk({3'h0, burst_mode}, 4'h0);
    tgt = 3'h7;
    cyc(40);
    fbl = 1'h0;
    cyc(1);
    fbl = 1'h1;
    cyc(40);
    chk({3'h0, burst_mode}, 4'h0);
    cyc(15);
    chk({3'h0, burst_mode}, 4'h1);
    wait_gate(1'h1, 1100);
    sw = 1'h1;
    cyc(10);
    chk({3'h0, latched_off}, 4'h0);
    sw = 1'h0;
    fbl = 1'h0;
    $display("burst test done");
    // out of burst, a lasting short-winding level must latch the gate off
    reset = 1'h1;
    cyc(2);
    reset = 1'h0;
    wait_gate(1'h1, 1100);
    sw = 1'h1;
    cyc(6);
    chk({3'h0, latched_off}, 4'h1);
    sw = 1'h0;
    $display("short-winding test done");
    end_of_test();
  end
endmodule : qrst_core_tb
